// *** include/smbus_cfg_pkg.sv ***
package smbus_cfg_pkg;

    // Command codes and byte counts seen on the bus
    localparam logic [7:0] CMD_SETUP_SEP     = 8'hba;
    localparam logic [7:0] CMD_SETUP_CALL    = 8'hcd;
    localparam logic [7:0] CMD_BLOCK_READ    = 8'hbd;
    localparam logic [7:0] SETUP_BYTE_COUNT  = 8'h04;
    localparam logic [7:0] RETURN_BYTE_COUNT = 8'h04;
    localparam logic [7:0] IDLE_FILL_BYTE    = 8'hff;

    // Operation field of the first setup byte
    localparam logic [2:0] OP_REG_WRITE = 3'h3;
    localparam logic [2:0] OP_REG_READ  = 3'h4;

    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h68;
    localparam int         PORT_COUNT         = 6;

    // Field positions inside the setup bytes
    localparam int PORT_HI_MSB = 3;
    localparam int PORT_LO_BIT = 7;
    localparam int BE_MSB      = 5;
    localparam int BE_LSB      = 2;
    localparam int ADDR_HI_MSB = 1;

    // Packet error code, CRC-8 with polynomial x^8 + x^2 + x + 1
    localparam logic [7:0] PEC_POLY = 8'h07;
    localparam logic [7:0] PEC_INIT = 8'h00;

    // Bit and byte positions within a transfer
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [1:0] SETUP_LAST = 2'h3;
    localparam logic [2:0] SEND_COUNT = 3'h0;
    localparam logic [2:0] SEND_DATA4 = 3'h4;
    localparam logic [2:0] SEND_PEC   = 3'h5;
    localparam logic [2:0] SEND_DONE  = 3'h6;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_ADDR   = 3'b001,
        PH_CMD    = 3'b010,
        PH_COUNT  = 3'b011,
        PH_SETUP  = 3'b100,
        PH_WAIT   = 3'b101,
        PH_SEND   = 3'b110,
        PH_IGNORE = 3'b111
    } link_phase_t;

    typedef struct packed {
        logic [4:0]  port;
        logic [3:0]  byte_en;
        logic [11:0] addr;
    } cfg_params_t;

    typedef struct packed {
        link_phase_t phase;
        logic [3:0]  bit_cnt;
        logic [6:0]  shift;
        logic        ack;
        logic [1:0]  setup_idx;
        logic        call_kind;
        logic        read_armed;
        logic        pec_allowed;
        logic [7:0]  crc;
        logic [7:0]  tx;
        logic [2:0]  send_idx;
        logic        start_seen;
        logic        stop_seen;
        logic [3:0]  port_hi;
        cfg_params_t pending;
        cfg_params_t params;
        logic        params_valid;
        logic        req_tgl;
        logic        ack_s1;
        logic        ack_s2;
    } link_state_t;

    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        req_seen;
        logic        busy;
        logic        rd_req;
        logic        ack_tgl;
        cfg_params_t params;
        logic [31:0] word;
    } core_state_t;

    typedef struct packed {
        logic oe;
        logic out;
    } line_drive_t;

    function automatic logic [7:0] pec_update(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

// *** rtl/bus_condition.sv ***
`timescale 1ns/10ps
// START and STOP happen while the clock line is high, so no clock edge sees
// them; each flips a toggle on the data edge and the link logic compares it.
module bus_condition (
    input  wire logic scl,
    input  wire logic sda_in,
    input  wire logic arst_n,
    output logic      start_tgl,
    output logic      stop_tgl
);

    always_ff @(negedge sda_in or negedge arst_n) begin
        if (!arst_n) begin
            start_tgl <= 1'b0;
        end else if (scl) begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge sda_in or negedge arst_n) begin
        if (!arst_n) begin
            stop_tgl <= 1'b0;
        end else if (scl) begin
            stop_tgl <= ~stop_tgl;
        end
    end

endmodule

// *** rtl/sda_driver.sv ***
`timescale 1ns/10ps
// Data line changes only while the clock line is low, hence the falling edge.
module sda_driver (
    input  wire logic scl,
    input  wire logic arst_n,
    input  wire logic drive_low,
    output logic      sda_out,
    output logic      sda_oe
);

    smbus_cfg_pkg::line_drive_t state;
    smbus_cfg_pkg::line_drive_t next_state;

    always_comb begin
        next_state.oe  = drive_low;
        next_state.out = 1'b0;
    end

    always_ff @(negedge scl or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sda_out = state.out;
    assign sda_oe  = state.oe;

endmodule

// *** rtl/smbus_cfg_read.sv ***
`timescale 1ns/10ps
// Operation
// - Port, dword address and byte enables from setup feed the following read.
// - Combined call: setup, repeated START without STOP, then read returns data.
// - First wrong byte and every later byte of the transaction are NACKed; the code NACKs only until the next START, repeated or not.
// - A byte requested after the fourth data byte is the PEC.
// - Master NACK on a returned byte ends the read; data line released.
// - Separate setup uses code BAh, count 04h, four setup bytes.
// - First setup byte bits 2:0: 011b write, 100b read; upper bits reserved.
// - Port index: second byte bits 3:0 high, third byte bit 7 low.
// - Port index selects the port; values 0 to 5 map directly.
// - Third byte bits 5:2 are byte enables, bit 2 for bits 7:0.
// - Address 11:10 from third byte 1:0, 9:2 from fourth byte, 1:0 zero.
// - Read uses code BDh; data returned bits 31:24 first, 7:0 last.
// - Device answers at seven-bit slave address 1101000b by default.
// - Combined call setup carries code CDh, other setup bytes unchanged.
// - Read returns byte count 04h before the four data bytes.
module smbus_cfg_read #(
    parameter logic [6:0] SLAVE_ADDR = smbus_cfg_pkg::DEFAULT_SLAVE_ADDR,
    parameter int         PORTS      = smbus_cfg_pkg::PORT_COUNT
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [31:0] cfg_rd_data,
    input  wire logic        cfg_rd_valid,
    output logic             cfg_rd_req,
    output logic [4:0]       cfg_port,
    output logic [3:0]       cfg_byte_en,
    output logic [11:0]      cfg_addr,
    output logic             cfg_busy
);

    initial begin
        if (PORTS < 1 || PORTS > 32) begin
            $error("PORTS must lie between 1 and 32");
        end
    end

    smbus_cfg_pkg::link_state_t l;
    smbus_cfg_pkg::link_state_t next_l;
    smbus_cfg_pkg::core_state_t c;
    smbus_cfg_pkg::core_state_t next_c;

    logic       start_tgl;
    logic       stop_tgl;
    logic       start_now;
    logic       new_frame;
    logic       data_ready;
    logic       drive_low;
    logic [7:0] rx_byte;
    logic [4:0] port_idx;

    bus_condition u_condition (
        .scl       (scl),
        .sda_in    (sda_in),
        .arst_n    (arst_n),
        .start_tgl (start_tgl),
        .stop_tgl  (stop_tgl)
    );

    function automatic logic [7:0] send_byte(input logic [2:0]  idx,
                                             input logic [31:0] word,
                                             input logic [7:0]  crc);
        case (idx)
            3'h1:    return word[31:24];
            3'h2:    return word[23:16];
            3'h3:    return word[15:8];
            3'h4:    return word[7:0];
            3'h5:    return crc;
            default: return smbus_cfg_pkg::IDLE_FILL_BYTE;
        endcase
    endfunction

    // The toggles settle while the clock line is high, at least half a bit
    // period before the next rising edge, so they are read without a synchroniser.
    assign start_now  = start_tgl != l.start_seen;
    assign new_frame  = stop_tgl != l.stop_seen;
    assign data_ready = l.ack_s2 == l.req_tgl;
    assign rx_byte    = {l.shift, sda_in};
    assign port_idx   = {l.port_hi, rx_byte[smbus_cfg_pkg::PORT_LO_BIT]};

    always_comb begin
        next_l        = l;
        next_l.ack_s1 = c.ack_tgl;
        next_l.ack_s2 = l.ack_s1;
        if (start_now) begin
            next_l.start_seen = start_tgl;
            next_l.stop_seen  = stop_tgl;
            next_l.phase      = smbus_cfg_pkg::PH_ADDR;
            next_l.bit_cnt    = 4'h1;
            next_l.shift      = {6'h00, sda_in};
            next_l.ack        = 1'b0;
            if (new_frame) begin
                next_l.crc        = smbus_cfg_pkg::PEC_INIT;
                next_l.read_armed = 1'b0;
            end
        end else if (l.phase != smbus_cfg_pkg::PH_IDLE) begin
            if (l.bit_cnt == smbus_cfg_pkg::BIT_ACK) begin
                next_l.bit_cnt = 4'h0;
                next_l.ack     = 1'b0;
                // Own address ACK is on the wire here, not a master answer
                if (l.phase == smbus_cfg_pkg::PH_SEND && !l.ack) begin
                    if (sda_in) begin
                        next_l.phase = smbus_cfg_pkg::PH_IDLE;
                    end else if (l.send_idx != smbus_cfg_pkg::SEND_DONE) begin
                        next_l.send_idx = l.send_idx + 3'h1;
                        next_l.tx = send_byte(l.send_idx + 3'h1, c.word, l.crc);
                    end else begin
                        next_l.tx = smbus_cfg_pkg::IDLE_FILL_BYTE;
                    end
                end
            end else begin
                next_l.bit_cnt = l.bit_cnt + 4'h1;
                next_l.shift   = rx_byte[6:0];
                if (l.bit_cnt == smbus_cfg_pkg::BIT_LAST) begin
                    if (l.phase == smbus_cfg_pkg::PH_SEND) begin
                        next_l.crc = smbus_cfg_pkg::pec_update(l.crc, l.tx);
                        next_l.ack = 1'b0;
                    end else begin
                        next_l.crc = smbus_cfg_pkg::pec_update(l.crc, rx_byte);
                        // Any refusal lands in PH_IGNORE until the next START
                        next_l.phase = smbus_cfg_pkg::PH_IGNORE;
                        next_l.ack   = 1'b0;
                        case (l.phase)
                            smbus_cfg_pkg::PH_ADDR: begin
                                if (rx_byte[7:1] == SLAVE_ADDR) begin
                                    if (!rx_byte[0]) begin
                                        next_l.ack   = 1'b1;
                                        next_l.phase = smbus_cfg_pkg::PH_CMD;
                                    end else if (l.read_armed && data_ready) begin
                                        next_l.ack        = 1'b1;
                                        next_l.phase      = smbus_cfg_pkg::PH_SEND;
                                        next_l.tx = smbus_cfg_pkg::RETURN_BYTE_COUNT;
                                        next_l.send_idx   = smbus_cfg_pkg::SEND_COUNT;
                                        next_l.read_armed = 1'b0;
                                    end
                                end
                            end
                            smbus_cfg_pkg::PH_CMD: begin
                                next_l.read_armed = 1'b0;
                                if (rx_byte == smbus_cfg_pkg::CMD_SETUP_SEP) begin
                                    next_l.ack       = 1'b1;
                                    next_l.phase     = smbus_cfg_pkg::PH_COUNT;
                                    next_l.call_kind = 1'b0;
                                end else if (rx_byte == smbus_cfg_pkg::CMD_SETUP_CALL) begin
                                    next_l.ack       = 1'b1;
                                    next_l.phase     = smbus_cfg_pkg::PH_COUNT;
                                    next_l.call_kind = 1'b1;
                                end else if (rx_byte == smbus_cfg_pkg::CMD_BLOCK_READ &&
                                             l.params_valid) begin
                                    next_l.ack         = 1'b1;
                                    next_l.phase       = smbus_cfg_pkg::PH_WAIT;
                                    next_l.read_armed  = 1'b1;
                                    next_l.pec_allowed = 1'b0;
                                end
                            end
                            smbus_cfg_pkg::PH_COUNT: begin
                                if (rx_byte == smbus_cfg_pkg::SETUP_BYTE_COUNT) begin
                                    next_l.ack       = 1'b1;
                                    next_l.phase     = smbus_cfg_pkg::PH_SETUP;
                                    next_l.setup_idx = 2'h0;
                                end
                            end
                            smbus_cfg_pkg::PH_SETUP: begin
                                next_l.setup_idx = l.setup_idx + 2'h1;
                                case (l.setup_idx)
                                    2'h0: begin
                                        // Write path lives elsewhere; only reads set up here
                                        if (rx_byte[2:0] == smbus_cfg_pkg::OP_REG_READ) begin
                                            next_l.ack   = 1'b1;
                                            next_l.phase = smbus_cfg_pkg::PH_SETUP;
                                        end
                                    end
                                    2'h1: begin
                                        next_l.port_hi = rx_byte[smbus_cfg_pkg::PORT_HI_MSB:0];
                                        next_l.ack     = 1'b1;
                                        next_l.phase   = smbus_cfg_pkg::PH_SETUP;
                                    end
                                    2'h2: begin
                                        if (32'(port_idx) < PORTS) begin
                                            next_l.pending.port = port_idx;
                                            next_l.pending.byte_en =
                                                rx_byte[smbus_cfg_pkg::BE_MSB:
                                                        smbus_cfg_pkg::BE_LSB];
                                            next_l.pending.addr[11:10] =
                                                rx_byte[smbus_cfg_pkg::ADDR_HI_MSB:0];
                                            next_l.ack   = 1'b1;
                                            next_l.phase = smbus_cfg_pkg::PH_SETUP;
                                        end
                                    end
                                    default: begin
                                        // A setup landing mid-fetch is refused, not merged
                                        if (data_ready) begin
                                            next_l.params      = l.pending;
                                            next_l.params.addr = {l.pending.addr[11:10],
                                                                  rx_byte, 2'b00};
                                            next_l.params_valid = 1'b1;
                                            next_l.req_tgl      = ~l.req_tgl;
                                            next_l.ack          = 1'b1;
                                            next_l.phase        = smbus_cfg_pkg::PH_WAIT;
                                            next_l.read_armed   = l.call_kind;
                                            next_l.pec_allowed  = 1'b1;
                                        end
                                    end
                                endcase
                            end
                            smbus_cfg_pkg::PH_WAIT: begin
                                if (l.pec_allowed && rx_byte == l.crc) begin
                                    next_l.ack         = 1'b1;
                                    next_l.phase       = smbus_cfg_pkg::PH_WAIT;
                                    next_l.pec_allowed = 1'b0;
                                end
                            end
                            default: begin
                                next_l.phase = smbus_cfg_pkg::PH_IGNORE;
                            end
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge scl or negedge arst_n) begin
        if (!arst_n) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    always_comb begin
        if (l.bit_cnt == smbus_cfg_pkg::BIT_ACK) begin
            drive_low = l.ack;
        end else if (l.phase == smbus_cfg_pkg::PH_SEND && l.bit_cnt <= smbus_cfg_pkg::BIT_LAST) begin
            drive_low = !l.tx[3'(smbus_cfg_pkg::BIT_LAST - l.bit_cnt)];
        end else begin
            drive_low = 1'b0;
        end
    end

    sda_driver u_driver (
        .scl       (scl),
        .arst_n    (arst_n),
        .drive_low (drive_low),
        .sda_out   (sda_out),
        .sda_oe    (sda_oe)
    );

    // Core side: request toggle synchronised, params stable until acknowledged
    always_comb begin
        next_c        = c;
        next_c.req_s1 = l.req_tgl;
        next_c.req_s2 = c.req_s1;
        next_c.rd_req = 1'b0;
        if (!c.busy && c.req_s2 != c.req_seen) begin
            next_c.req_seen = c.req_s2;
            next_c.busy     = 1'b1;
            next_c.rd_req   = 1'b1;
            next_c.params   = l.params;
        end else if (c.busy && !c.rd_req && cfg_rd_valid) begin
            next_c.word    = cfg_rd_data;
            next_c.busy    = 1'b0;
            next_c.ack_tgl = ~c.ack_tgl;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    assign cfg_rd_req  = c.rd_req;
    assign cfg_port    = c.params.port;
    assign cfg_byte_en = c.params.byte_en;
    assign cfg_addr    = c.params.addr;
    assign cfg_busy    = c.busy;

    a_count_first: assert property (@(posedge scl) disable iff (!arst_n)
        (l.phase != smbus_cfg_pkg::PH_SEND ##1 l.phase == smbus_cfg_pkg::PH_SEND)
        |-> (l.tx == smbus_cfg_pkg::RETURN_BYTE_COUNT && l.send_idx == smbus_cfg_pkg::SEND_COUNT))
        else $error("Read did not open with the byte count");

    a_data_order: assert property (@(posedge scl) disable iff (!arst_n)
        (l.phase == smbus_cfg_pkg::PH_SEND && l.bit_cnt == smbus_cfg_pkg::BIT_ACK
         && !sda_in && !start_now && !l.ack && l.send_idx == smbus_cfg_pkg::SEND_COUNT)
        |=> (l.tx == c.word[31:24] && l.send_idx == 3'h1))
        else $error("First data byte is not bits 31:24");

    a_pec_follows: assert property (@(posedge scl) disable iff (!arst_n)
        (l.phase == smbus_cfg_pkg::PH_SEND && l.bit_cnt == smbus_cfg_pkg::BIT_ACK
         && !sda_in && !start_now && !l.ack && l.send_idx == smbus_cfg_pkg::SEND_DATA4)
        |=> (l.tx == $past(l.crc) && l.send_idx == smbus_cfg_pkg::SEND_PEC))
        else $error("Byte after fourth data byte is not the PEC");

    a_nack_release: assert property (@(posedge scl) disable iff (!arst_n)
        (l.phase == smbus_cfg_pkg::PH_SEND && l.bit_cnt == smbus_cfg_pkg::BIT_ACK
         && sda_in && !start_now)
        |=> (!drive_low && l.phase == smbus_cfg_pkg::PH_IDLE)[*2] ##1 (!drive_low)[*2])
        else $error("Data line still driven after master NACK");

    a_ignore_sticks: assert property (@(posedge scl) disable iff (!arst_n)
        (l.phase == smbus_cfg_pkg::PH_IGNORE && !start_now)
        |=> l.phase == smbus_cfg_pkg::PH_IGNORE)
        else $error("Refused transaction resumed before a START");

    a_ignore_silent: assert property (@(posedge scl) disable iff (!arst_n)
        l.phase == smbus_cfg_pkg::PH_IGNORE |-> !drive_low)
        else $error("Acknowledge given after a wrong byte");

    a_foreign_addr: assert property (@(posedge scl) disable iff (!arst_n)
        (l.phase == smbus_cfg_pkg::PH_ADDR && l.bit_cnt == smbus_cfg_pkg::BIT_LAST
         && !start_now && rx_byte[7:1] != SLAVE_ADDR)
        |=> (l.phase == smbus_cfg_pkg::PH_IGNORE && !drive_low))
        else $error("Foreign slave address acknowledged");

    a_call_arms: assert property (@(posedge scl) disable iff (!arst_n)
        (l.phase == smbus_cfg_pkg::PH_SETUP && l.setup_idx == smbus_cfg_pkg::SETUP_LAST
         && l.bit_cnt == smbus_cfg_pkg::BIT_LAST && !start_now && l.call_kind && data_ready)
        |=> (l.read_armed && l.params_valid && l.ack && l.req_tgl != $past(l.req_tgl)))
        else $error("Combined call setup did not arm the read");

    a_fetch_params: assert property (@(posedge clock) disable iff (!arst_n)
        c.rd_req |-> (cfg_addr[1:0] == 2'b00 && 32'(cfg_port) < PORTS && c.busy))
        else $error("Fetch issued with bad port or address");

    a_fetch_pulse: assert property (@(posedge clock) disable iff (!arst_n)
        c.rd_req |=> (!c.rd_req && c.req_seen == $past(c.req_seen)))
        else $error("Fetch request longer than one cycle");

    c_read_pec: cover property (@(posedge scl) disable iff (!arst_n)
        l.phase == smbus_cfg_pkg::PH_SEND && l.send_idx == smbus_cfg_pkg::SEND_PEC);

    c_combined: cover property (@(posedge scl) disable iff (!arst_n)
        l.call_kind && l.read_armed && start_now && !new_frame);

    c_refused: cover property (@(posedge scl) disable iff (!arst_n)
        l.phase == smbus_cfg_pkg::PH_IGNORE && l.params_valid);

    c_fetch_done: cover property (@(posedge clock) disable iff (!arst_n)
        c.busy && cfg_rd_valid && !c.rd_req);

endmodule

// *** verification/smbus_master_model.sv ***
`timescale 1ns/10ps
// Open-drain master; sda_drv high means released, clock stands high between frames
module smbus_master_model (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda
);
    logic [7:0] crc;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        crc = 8'h00;
    end
    // b low: START or repeated START, b high: STOP
    task automatic cond(input logic b);
        sda_drv = ~b;
        #20 scl = 1'b1;
        #40 sda_drv = b;
        #40 scl = b;
    endtask
    // Running CRC of wire bytes gives the expected PEC
    task automatic xfer(input logic [7:0] w, input logic a_in, output logic [7:0] r,
                        output logic a);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = w[i];
            #20 scl = 1'b1;
            #20 r[i] = sda;
            #40 scl = 1'b0;
        end
        crc = crc ^ r;
        for (int i = 0; i < 8; i++) begin
            crc = crc[7] ? ((crc << 1) ^ 8'h07) : (crc << 1);
        end
        sda_drv = a_in;
        #20 scl = 1'b1;
        #20 a = sda;
        #40 scl = 1'b0;
    endtask
endmodule

// *** verification/smbus_cfg_read_tb.sv ***
`timescale 1ns/10ps
module smbus_cfg_read_tb;
    logic        clock = 1'b0;
    logic        arst_n;
    logic        scl, sda_drv, sda_out, sda_oe, cfg_rd_req, cfg_busy, a;
    logic [4:0]  cfg_port;
    logic [3:0]  cfg_byte_en;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_rd_data;
    logic        cfg_rd_valid;
    logic [7:0]  r;
    wire logic   sda_in;
    int          error_cnt = 0;
    int          n_checks = 0;
    assign sda_in = sda_drv & ~sda_oe;
    always #20 clock = ~clock;
    smbus_cfg_read dut (.clock(clock), .arst_n(arst_n), .scl(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .cfg_rd_data(cfg_rd_data),
        .cfg_rd_valid(cfg_rd_valid), .cfg_rd_req(cfg_rd_req), .cfg_port(cfg_port),
        .cfg_byte_en(cfg_byte_en), .cfg_addr(cfg_addr), .cfg_busy(cfg_busy));
    smbus_master_model master (.scl(scl), .sda_drv(sda_drv), .sda(sda_in));
    // Core answers the cycle after the request, word encodes the fetch fields
    always @(posedge clock) begin
        if (!arst_n) begin
            cfg_rd_valid <= 1'b0;
            cfg_rd_data  <= 32'h0;
        end else begin
            cfg_rd_valid <= cfg_rd_req;
            if (cfg_rd_req === 1'b1) begin
                cfg_rd_data <= {cfg_addr[11:2], 1'b0, cfg_port, 8'ha5, cfg_byte_en, 4'h0};
            end
        end
    end
    function automatic logic [31:0] expw(logic [11:0] ad, logic [4:0] p, logic [3:0] be);
        return {ad[11:2], 1'b0, p, 8'ha5, be, 4'h0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] b, input logic ea);
        master.xfer(b, 1'b1, r, a);
        chk({7'h0, a}, {7'h0, ea});
    endtask
    task automatic rd(input logic [7:0] e, input logic nack);
        master.xfer(8'hff, nack, r, a);
        chk(r, e);
    endtask
    // Ack mask: one wire ack level per byte, 0 accepted, 1 refused
    task automatic send(input logic [55:0] s, input logic [6:0] ak);
        for (int i = 6; i >= 0; i--) wr(s[i*8 +: 8], ak[i]);
    endtask
    task automatic readback(input logic [31:0] w, input logic pec);
        logic [7:0] e;
        master.cond(1'b0);
        wr(8'hd1, 1'b0);
        rd(8'h04, 1'b0);
        for (int i = 3; i > 0; i--) rd(w[i*8 +: 8], 1'b0);
        rd(w[7:0], ~pec);
        e = master.crc;
        if (pec) rd(e, 1'b1);
        master.cond(1'b1);
        chk({6'h0, sda_out, sda_oe}, 8'h00);
        chk({7'h0, cfg_busy}, 8'h00);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        // Drop after time zero so the asynchronous reset edge is seen
        #1 arst_n = 1'b0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        master.cond(1'b0);
        wr(8'hd0, 1'b0);
        wr(8'hbd, 1'b1);
        master.cond(1'b1);
        master.crc = 8'h00;
        $display("read without setup done");
        master.cond(1'b0);
        send({8'hd0, 8'hba, 8'h04, 8'h04, 8'h00, 8'hbc, 8'h3e}, 7'h00);
        wr(master.crc, 1'b0);
        master.cond(1'b1);
        master.crc = 8'h00;
        master.cond(1'b0);
        wr(8'hd0, 1'b0);
        wr(8'hbd, 1'b0);
        readback(expw(12'h0f8, 5'h01, 4'hf), 1'b1);
        $display("separate read done");
        master.cond(1'b0);
        send({8'hd0, 8'hcd, 8'h04, 8'h04, 8'h02, 8'h97, 8'h81}, 7'h00);
        readback(expw(12'he04, 5'h05, 4'h5), 1'b0);
        $display("combined read done");
        master.cond(1'b0);
        send({8'hd0, 8'hba, 8'h04, 8'h03, 8'h00, 8'hbc, 8'h3e}, 7'h0f);
        master.cond(1'b0);
        send({8'hd0, 8'hba, 8'h04, 8'h04, 8'h03, 8'h3c, 8'h3e}, 7'h03);
        master.cond(1'b0);
        send({8'hd0, 8'hba, 8'h05, 8'h04, 8'h00, 8'hbc, 8'h3e}, 7'h1f);
        master.cond(1'b0);
        send({8'hd2, 8'hba, 8'h04, 8'h04, 8'h00, 8'hbc, 8'h3e}, 7'h7f);
        master.cond(1'b1);
        $display("refusal test done");
        print_verdict();
    end
endmodule
